// File: src/mac_receive_control.sv
// receive control of the ethernet mac: size limits, truncation, fcs strip, enable
// Behaviour
// - 14-bit max frame size, reset 1518; longer frames are flagged too long, and aborted at max plus one only with truncation select 0.
// - any frame beyond 11264 bytes is truncated; the watchdog cuts it at 11265 unless select 0 cuts it earlier.
// - truncation select 0: cut at max plus one, report that length, too long set.
// - truncation select 1 (reset): cut at 11265, too long and watchdog flags set.
// - fcs strip set drops the final four bytes of every frame; reset clear.
// - tag enforcement clear: limit is the max size whatever the tagging.
// - tag enforcement set: limit grows by four per vlan tag, up to two tags.
// - frames are accepted only while rx_on is set; rx_on resets to zero.
// - clearing rx_on mid-frame lets that frame finish before the receiver stops.
// - disabled flag sets when stopping completes; software clears it by writing one.

// ==========================================================
// fifo between the receiver and the fifo controller
module rx_fifo #(
  parameter int WIDTH = 18,
  parameter int DEPTH = 32
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  // count is one bit wider than the pointers so full and empty stay distinct
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
  localparam logic [CW-1:0] FULL = CW'(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [CW-1:0] count;
  } fifo_state_t;

  fifo_state_t s_r;
  fifo_state_t s_nxt;
  logic push;
  logic pop;

  assign in_ready = (s_r.count != FULL);
  assign out_valid = (s_r.count != '0);
  assign out_data = s_r.mem[s_r.rd_ptr];

  always_comb begin
    s_nxt = s_r;
    push = in_valid && in_ready;
    pop = out_valid && out_ready;
    // in_ready is low when full, so a push never lands on the unread slot
    if (push) begin
      s_nxt.mem[s_r.wr_ptr] = in_data;
      s_nxt.wr_ptr = (s_r.wr_ptr == LAST) ? '0 : s_r.wr_ptr + 1'b1;
    end
    if (pop) begin
      s_nxt.rd_ptr = (s_r.rd_ptr == LAST) ? '0 : s_r.rd_ptr + 1'b1;
    end
    if (push && !pop) begin
      s_nxt.count = s_r.count + 1'b1;
    end else if (pop && !push) begin
      s_nxt.count = s_r.count - 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end
endmodule : rx_fifo

// ==========================================================
// receive control top
module mac_receive_control
  import rx_ctrl_pkg::*;
#(
  parameter int FIFO_DEPTH = 32
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic phy_rx_dv,
  input wire logic [7:0] phy_rx_data,
  output logic rx_fifo_ctrl_valid,
  input wire logic rx_fifo_ctrl_ready,
  output rx_ctrl_pkg::rx_fifo_entry_t rx_fifo_ctrl_data
);
  import rx_ctrl_pkg::*;

  typedef struct packed {
    logic dv_meta;
    logic dv_sync;
    logic dv_prev;
    logic [7:0] data_meta;
    logic [7:0] data_sync;
    mac_receive_config_t cfg;
    logic running;
    logic wr_pend;
    logic addr_hit;
    logic [31:0] rdata;
    rx_state_t state;
    logic [14:0] len;
    logic [3:0][7:0] dly;
    logic [2:0] dly_cnt;
    logic [2:0] flush_left;
    logic tpid_hi;
    logic one_tag;
    logic two_tag;
    rx_status_word_a_t stat;
  } rx_state_all_t;

  localparam rx_state_all_t RST_STATE = '{
    cfg: '{max_size: MAX_SIZE_RST, trunc_len_select: TRUNC_SEL_RST,
           fcs_strip: FCS_STRIP_RST, tag_size_enforce: TAG_ENFORCE_RST,
           rx_disabled: RX_DISABLED_RST, rx_on: RX_ON_RST},
    state: ST_IDLE,
    default: '0
  };

  rx_state_all_t s_r;
  rx_state_all_t s_nxt;
  logic fifo_in_valid;
  logic fifo_in_ready;
  rx_fifo_entry_t fifo_in_data;
  logic [$bits(rx_fifo_entry_t)-1:0] fifo_out_bits;
  logic bus_req;
  logic [14:0] limit;
  logic [14:0] cut;
  logic [14:0] limit_plus1;
  logic [14:0] new_len;
  logic [7:0] b;

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = s_r.rdata;
  assign rx_fifo_ctrl_data = rx_fifo_entry_t'(fifo_out_bits);
  // zero wait states: a word transfer is taken at its address phase
  assign bus_req = hsel && hready && htrans[1] && (hsize == 3'h2);

  always_comb begin
    s_nxt = s_r;
    fifo_in_valid = 1'b0;
    fifo_in_data = '0;
    b = s_r.data_sync;
    new_len = s_r.len + 15'h0001;

    // pins pass two flops before use
    s_nxt.dv_meta = phy_rx_dv;
    s_nxt.dv_sync = s_r.dv_meta;
    s_nxt.data_meta = phy_rx_data;
    s_nxt.data_sync = s_r.data_meta;
    s_nxt.dv_prev = s_r.dv_sync;

    // ==========================================================
    // register writes (data phase)
    s_nxt.wr_pend = 1'b0;
    if (bus_req) begin
      s_nxt.wr_pend = hwrite;
      s_nxt.addr_hit = (haddr == ADDR_RX_CONFIG);
    end
    if (s_r.wr_pend && s_r.addr_hit) begin
      s_nxt.cfg.max_size = hwdata[MAX_SIZE_LSB +: MAX_SIZE_W];
      s_nxt.cfg.trunc_len_select = hwdata[BIT_TRUNC_SEL];
      s_nxt.cfg.fcs_strip = hwdata[BIT_FCS_STRIP];
      s_nxt.cfg.tag_size_enforce = hwdata[BIT_TAG_ENFORCE];
      s_nxt.cfg.rx_on = hwdata[BIT_RX_ON];
      // write-one-to-clear; a set from the receiver below still wins
      if (hwdata[BIT_RX_DISABLED]) begin
        s_nxt.cfg.rx_disabled = 1'b0;
      end
    end

    // ==========================================================
    // size limits
    limit = {1'b0, s_r.cfg.max_size};
    if (s_r.cfg.tag_size_enforce) begin
      if (s_r.two_tag) begin
        limit = limit + TWO_TAG_BYTES;
      end else if (s_r.one_tag) begin
        limit = limit + ONE_TAG_BYTES;
      end
    end
    limit_plus1 = limit + 15'h0001;
    // watchdog cut bounds both settings
    if (s_r.cfg.trunc_len_select || limit_plus1 > WDT_CUT) begin
      cut = WDT_CUT;
    end else begin
      cut = limit_plus1;
    end

    // ==========================================================
    // receive path
    unique case (s_r.state)
      ST_IDLE: begin
        if (s_r.cfg.rx_on) begin
          s_nxt.running = 1'b1;
        end else if (s_r.running) begin
          // stop only here, so a frame in flight always completes
          s_nxt.running = 1'b0;
          s_nxt.cfg.rx_disabled = 1'b1;
        end
        // start on a fresh rising dv, never mid-frame
        if (s_r.cfg.rx_on && s_r.running && s_r.dv_sync && !s_r.dv_prev) begin
          s_nxt.state = ST_RECV;
          s_nxt.len = 15'h0001;
          s_nxt.dly[0] = b;
          s_nxt.dly_cnt = 3'h1;
          s_nxt.tpid_hi = 1'b0;
          s_nxt.one_tag = 1'b0;
          s_nxt.two_tag = 1'b0;
          s_nxt.stat = '0;
        end
      end
      ST_RECV: begin
        if (s_r.dv_sync) begin
          // tags are only looked for at fixed offsets: outer, then inner
          if (s_r.len == OUTER_TPID_POS || s_r.len == INNER_TPID_POS) begin
            s_nxt.tpid_hi = (b == TPID_HI);
          end
          if (s_r.len == OUTER_TPID_POS + 15'h0001) begin
            s_nxt.one_tag = s_r.tpid_hi && (b == TPID_LO);
          end
          if (s_r.len == INNER_TPID_POS + 15'h0001) begin
            s_nxt.two_tag = s_r.one_tag && s_r.tpid_hi && (b == TPID_LO);
          end
          s_nxt.len = new_len;
          if (new_len > limit) begin
            s_nxt.stat.too_long = 1'b1;
          end
          if (new_len > WDT_LIMIT) begin
            // a watchdog cut always counts as too long, whatever the max size
            s_nxt.stat.watchdog_trunc_flag = 1'b1;
            s_nxt.stat.too_long = 1'b1;
          end
          s_nxt.dly = {s_r.dly[2:0], b};
          // four-byte delay line lets the fcs be held back
          if (s_r.dly_cnt == FCS_BYTES) begin
            fifo_in_valid = 1'b1;
            fifo_in_data.payload = {9'h000, s_r.dly[3]};
            if (!fifo_in_ready) begin
              // a phy cannot be stalled: the byte is lost and reported
              s_nxt.stat.overflow = 1'b1;
            end
          end else begin
            s_nxt.dly_cnt = s_r.dly_cnt + 3'h1;
          end
          if (new_len == cut) begin
            s_nxt.state = ST_DROP;
          end
        end else begin
          s_nxt.state = ST_FLUSH;
          s_nxt.flush_left = s_r.cfg.fcs_strip ? 3'h0 : s_r.dly_cnt;
        end
      end
      ST_DROP: begin
        // rest of a cut frame is discarded until dv drops
        if (!s_r.dv_sync) begin
          s_nxt.state = ST_FLUSH;
          s_nxt.flush_left = s_r.cfg.fcs_strip ? 3'h0 : s_r.dly_cnt;
        end
      end
      ST_FLUSH: begin
        // held bytes leave oldest first, waiting on the fifo
        if (s_r.flush_left == 3'h0) begin
          s_nxt.state = ST_STATUS;
        end else begin
          fifo_in_valid = 1'b1;
          fifo_in_data.payload = {9'h000, s_r.dly[2'(s_r.flush_left - 3'h1)]};
          if (fifo_in_ready) begin
            s_nxt.flush_left = s_r.flush_left - 3'h1;
          end
        end
      end
      ST_STATUS: begin
        // one status word closes every frame, cut or whole
        fifo_in_valid = 1'b1;
        fifo_in_data.is_status = 1'b1;
        fifo_in_data.payload = {s_r.stat.overflow, s_r.stat.watchdog_trunc_flag,
                                s_r.stat.too_long, s_r.len[13:0]};
        if (fifo_in_ready) begin
          s_nxt.state = ST_IDLE;
        end
      end
    endcase

    // ==========================================================
    // register read, registered at the address phase
    if (bus_req && !hwrite) begin
      // reserved bits and unmapped words read as zero
      s_nxt.rdata = '0;
      if (haddr == ADDR_RX_CONFIG) begin
        s_nxt.rdata[MAX_SIZE_LSB +: MAX_SIZE_W] = s_nxt.cfg.max_size;
        s_nxt.rdata[BIT_TRUNC_SEL] = s_nxt.cfg.trunc_len_select;
        s_nxt.rdata[BIT_FCS_STRIP] = s_nxt.cfg.fcs_strip;
        s_nxt.rdata[BIT_TAG_ENFORCE] = s_nxt.cfg.tag_size_enforce;
        s_nxt.rdata[BIT_RX_DISABLED] = s_nxt.cfg.rx_disabled;
        s_nxt.rdata[BIT_RX_ON] = s_nxt.cfg.rx_on;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_r <= RST_STATE;
    end else begin
      s_r <= s_nxt;
    end
  end

  rx_fifo #(
    .WIDTH($bits(rx_fifo_entry_t)),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .hclk(hclk),
    .hresetn(hresetn),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .in_data(fifo_in_data),
    .out_valid(rx_fifo_ctrl_valid),
    .out_ready(rx_fifo_ctrl_ready),
    .out_data(fifo_out_bits)
  );

endmodule : mac_receive_control

// File: src/rx_ctrl_pkg.sv
// shared constants and carrier types of the receive control block
package rx_ctrl_pkg;

  // ==========================================================
  // register map
  localparam logic [31:0] ADDR_RX_CONFIG = 32'h0000_0104;
  localparam int BIT_RX_ON = 0;
  localparam int BIT_RX_DISABLED = 1;
  localparam int BIT_TAG_ENFORCE = 2;
  localparam int BIT_FCS_STRIP = 4;
  localparam int BIT_TRUNC_SEL = 5;
  localparam int MAX_SIZE_LSB = 16;
  localparam int MAX_SIZE_W = 14;

  // ==========================================================
  // reset values
  localparam logic [13:0] MAX_SIZE_RST = 14'h5EE;
  localparam logic TRUNC_SEL_RST = 1'h1;
  localparam logic FCS_STRIP_RST = 1'h0;
  localparam logic TAG_ENFORCE_RST = 1'h0;
  localparam logic RX_ON_RST = 1'h0;
  localparam logic RX_DISABLED_RST = 1'h0;

  // ==========================================================
  // frame lengths and offsets in bytes, tag identifier byte values
  localparam logic [14:0] WDT_LIMIT = 15'h2C00;
  localparam logic [14:0] WDT_CUT = 15'h2C01;
  localparam logic [14:0] ONE_TAG_BYTES = 15'h0004;
  localparam logic [14:0] TWO_TAG_BYTES = 15'h0008;
  localparam logic [2:0] FCS_BYTES = 3'h4;
  localparam logic [14:0] OUTER_TPID_POS = 15'h000C;
  localparam logic [14:0] INNER_TPID_POS = 15'h0010;
  localparam logic [7:0] TPID_HI = 8'h81;
  localparam logic [7:0] TPID_LO = 8'h00;

  // ==========================================================
  // carriers
  typedef struct packed {
    logic [13:0] max_size;
    logic trunc_len_select;
    logic fcs_strip;
    logic tag_size_enforce;
    logic rx_disabled;
    logic rx_on;
  } mac_receive_config_t;

  typedef struct packed {
    logic overflow;
    logic watchdog_trunc_flag;
    logic too_long;
    logic [13:0] length;
  } rx_status_word_a_t;

  typedef struct packed {
    logic is_status;
    logic [16:0] payload;
  } rx_fifo_entry_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_RECV = 3'b001,
    ST_DROP = 3'b010,
    ST_FLUSH = 3'b011,
    ST_STATUS = 3'b100
  } rx_state_t;

endpackage : rx_ctrl_pkg

// File: tb/mac_receive_control_sva.sv
// port assertions of the receive control block
module mac_receive_control_sva
  import rx_ctrl_pkg::*;
#(
  parameter int FIFO_DEPTH = 32
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic rx_fifo_ctrl_valid,
  input wire logic rx_fifo_ctrl_ready,
  input wire rx_ctrl_pkg::rx_fifo_entry_t rx_fifo_ctrl_data
);
  timeunit 1ns;
  timeprecision 1ps;
  rx_status_word_a_t st;
  logic take;
  logic wrote_r;
  assign st = rx_fifo_ctrl_data.payload;
  assign take = rx_fifo_ctrl_valid && rx_fifo_ctrl_ready && rx_fifo_ctrl_data.is_status;
  // no write yet: rx_on still at its reset value
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wrote_r <= 1'b0;
    end else if (hsel && hready && htrans[1] && hwrite) begin
      wrote_r <= 1'b1;
    end
  end
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  // ==========================================================
  // properties
  sequence s_rd;
    hsel && hready && htrans[1] && !hwrite && hsize == 3'h2;
  endsequence
  sequence s_stall;
    rx_fifo_ctrl_valid && !rx_fifo_ctrl_ready;
  endsequence
  AST_RSVD: assert property (
    s_rd ##0 haddr == ADDR_RX_CONFIG |=> (hrdata & 32'hC000_FFC8) == 32'h0)
    else $error("reserved bits read nonzero");
  AST_UNMAP: assert property (s_rd ##0 haddr != ADDR_RX_CONFIG |=> hrdata == 32'h0)
    else $error("unmapped read nonzero");
  AST_HOLD: assert property (s_stall |=> rx_fifo_ctrl_valid && $stable(rx_fifo_ctrl_data))
    else $error("entry changed while stalled");
  AST_QUIET: assert property (!wrote_r |-> !rx_fifo_ctrl_valid)
    else $error("entry while receiver off");
  AST_CAP: assert property (take |-> {1'b0, st.length} <= WDT_CUT)
    else $error("length beyond cut");
  AST_WDT_LEN: assert property (
    take && st.watchdog_trunc_flag |-> {1'b0, st.length} > WDT_LIMIT)
    else $error("watchdog flag on short frame");
  AST_WDT_SET: assert property (
    take && {1'b0, st.length} > WDT_LIMIT |-> st.watchdog_trunc_flag)
    else $error("watchdog flag missing");
  AST_WDT_LONG: assert property (take && st.watchdog_trunc_flag |-> st.too_long)
    else $error("watchdog without too long");
endmodule : mac_receive_control_sva

bind mac_receive_control mac_receive_control_sva #(.FIFO_DEPTH(FIFO_DEPTH)) u_sva (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hsize(hsize), .hready(hready), .hrdata(hrdata),
  .rx_fifo_ctrl_valid(rx_fifo_ctrl_valid), .rx_fifo_ctrl_ready(rx_fifo_ctrl_ready),
  .rx_fifo_ctrl_data(rx_fifo_ctrl_data)
);

// File: tb/phy_fct_model.sv
// phy receive side and fifo controller sink model
module phy_fifo_ctrl_model
  import rx_ctrl_pkg::*;
(
  input wire logic hclk,
  output logic phy_rx_dv,
  output logic [7:0] phy_rx_data,
  input wire logic rx_fifo_ctrl_valid,
  output logic rx_fifo_ctrl_ready,
  input wire rx_ctrl_pkg::rx_fifo_entry_t rx_fifo_ctrl_data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic stall;
  int n_stat;
  rx_fifo_entry_t got[$];
  initial begin
    phy_rx_dv = 1'b0;
    phy_rx_data = 8'h00;
    rx_fifo_ctrl_ready = 1'b1;
    stall = 1'b0;
    n_stat = 0;
  end
  always @(posedge hclk) begin
    if (rx_fifo_ctrl_valid && rx_fifo_ctrl_ready) begin
      got.push_back(rx_fifo_ctrl_data);
      n_stat += rx_fifo_ctrl_data.is_status;
    end
    rx_fifo_ctrl_ready <= !stall;
  end
  // frame from destination address through fcs, tags at bytes 12 and 16
  task automatic send(input int n, input int tags);
    logic [7:0] b;
    for (int i = 0; i < n; i++) begin
      b = i[7:0];
      if ((i == 12 && tags > 0) || (i == 16 && tags > 1)) b = TPID_HI;
      if ((i == 13 && tags > 0) || (i == 17 && tags > 1)) b = TPID_LO;
      @(posedge hclk);
      phy_rx_dv <= 1'b1;
      phy_rx_data <= b;
    end
    @(posedge hclk);
    phy_rx_dv <= 1'b0;
    // idle line shows the inverse so a stale byte cannot pass
    phy_rx_data <= ~b;
  endtask : send
endmodule : phy_fifo_ctrl_model

// File: tb/tb_top.sv
// self-checking bench of the receive control block
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import rx_ctrl_pkg::*;
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic phy_rx_dv, rx_fifo_ctrl_valid, rx_fifo_ctrl_ready;
  logic [7:0] phy_rx_data;
  rx_fifo_entry_t rx_fifo_ctrl_data;
  int fails, n_checks, cyc;
  assign hready = hreadyout;
  mac_receive_control #(.FIFO_DEPTH(32)) dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .phy_rx_dv(phy_rx_dv),
    .phy_rx_data(phy_rx_data), .rx_fifo_ctrl_valid(rx_fifo_ctrl_valid),
    .rx_fifo_ctrl_ready(rx_fifo_ctrl_ready), .rx_fifo_ctrl_data(rx_fifo_ctrl_data));
  phy_fifo_ctrl_model phy (
    .hclk(hclk), .phy_rx_dv(phy_rx_dv), .phy_rx_data(phy_rx_data),
    .rx_fifo_ctrl_valid(rx_fifo_ctrl_valid), .rx_fifo_ctrl_ready(rx_fifo_ctrl_ready),
    .rx_fifo_ctrl_data(rx_fifo_ctrl_data));
  // ==========================================================
  // shared tasks
  task end_sim;
    if (fails == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : end_sim
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'b10;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    rd = hrdata;
    chk(hresp, 1'b0);
  endtask : ahb
  function automatic logic [31:0] cfg(input logic [13:0] mx, input logic sl, st, en, on);
    return {2'b00, mx, 10'h000, sl, st, 1'b0, en, 1'b0, on};
  endfunction : cfg
  task automatic setup(input logic [13:0] mx, input logic sl, st, en);
    ahb(1'b0, ADDR_RX_CONFIG, 32'h0);
    ahb(1'b1, ADDR_RX_CONFIG, rd & ~32'h3);
    ahb(1'b1, ADDR_RX_CONFIG, cfg(mx, sl, st, en, 1'b0) | 32'h2);
    ahb(1'b1, ADDR_RX_CONFIG, cfg(mx, sl, st, en, 1'b1));
    repeat (4) @(posedge hclk);
    phy.got.delete();
    phy.n_stat = 0;
  endtask : setup
  task automatic expect_frame(input int nd, input logic [16:0] st);
    int k;
    for (k = 0; k < 30000 && phy.n_stat == 0; k++) @(posedge hclk);
    repeat (2) @(posedge hclk);
    chk(phy.n_stat, 1);
    k = phy.got.size() - 1;
    chk(phy.got[k], {1'b1, st});
    if (nd >= 0) chk(k, nd);
    for (int i = 0; i < nd; i++) begin
      chk({phy.got[i].is_status, phy.got[i].payload[7:0]}, {1'b0, i[7:0]});
    end
    phy.got.delete();
    phy.n_stat = 0;
  endtask : expect_frame
  // ==========================================================
  // scenarios
  task t_regs;
    ahb(1'b0, ADDR_RX_CONFIG, 32'h0);
    chk(rd, 32'h05EE_0020);
    ahb(1'b0, 32'h0000_0108, 32'h0);
    chk(rd, 32'h0);
    phy.send(40, 0);
    repeat (40) @(posedge hclk);
    chk(phy.got.size(), 0);
  endtask : t_regs
  task t_frames;
    setup(14'd1518, 1'b1, 1'b0, 1'b0);
    phy.send(64, 0);
    expect_frame(64, {3'b000, 14'd64});
    setup(14'd1518, 1'b1, 1'b1, 1'b0);
    phy.send(64, 0);
    expect_frame(60, {3'b000, 14'd64});
    setup(14'd100, 1'b0, 1'b0, 1'b0);
    phy.send(150, 0);
    expect_frame(101, {3'b001, 14'd101});
  endtask : t_frames
  task automatic t_tags;
    int nb[6] = '{104, 105, 108, 109, 101, 104};
    int tg[6] = '{1, 1, 2, 2, 0, 1};
    int ln[6] = '{104, 105, 108, 109, 101, 101};
    bit [5:0] en = 6'b011111;
    bit [5:0] lg = 6'b111010;
    for (int i = 0; i < 6; i++) begin
      setup(14'd100, 1'b0, 1'b0, en[i]);
      phy.send(nb[i], tg[i]);
      expect_frame(-1, {2'b00, lg[i], ln[i][13:0]});
    end
  endtask : t_tags
  task t_long;
    setup(14'd1518, 1'b1, 1'b0, 1'b0);
    phy.send(1600, 0);
    expect_frame(1600, {3'b001, 14'd1600});
    phy.send(11300, 0);
    expect_frame(-1, {3'b011, 14'd11265});
  endtask : t_long
  task t_fifo;
    setup(14'd1518, 1'b1, 1'b0, 1'b0);
    phy.stall = 1'b1;
    phy.send(40, 0);
    repeat (20) @(posedge hclk);
    chk(rx_fifo_ctrl_valid, 1'b1);
    chk(phy.got.size(), 0);
    phy.stall = 1'b0;
    expect_frame(-1, {3'b100, 14'd40});
    chk(rx_fifo_ctrl_valid, 1'b0);
  endtask : t_fifo
  task t_disable;
    setup(14'd1518, 1'b1, 1'b0, 1'b0);
    fork
      phy.send(64, 0);
      begin
        repeat (20) @(posedge hclk);
        ahb(1'b1, ADDR_RX_CONFIG, cfg(14'd1518, 1'b1, 1'b0, 1'b0, 1'b0));
        ahb(1'b0, ADDR_RX_CONFIG, 32'h0);
        chk(rd[1], 1'b0);
      end
    join
    expect_frame(64, {3'b000, 14'd64});
    ahb(1'b0, ADDR_RX_CONFIG, 32'h0);
    chk(rd[1:0], 2'b10);
    ahb(1'b1, ADDR_RX_CONFIG, cfg(14'd1518, 1'b1, 1'b0, 1'b0, 1'b0) | 32'h2);
    ahb(1'b0, ADDR_RX_CONFIG, 32'h0);
    chk(rd[1:0], 2'b00);
    phy.send(40, 0);
    repeat (40) @(posedge hclk);
    chk(phy.got.size(), 0);
  endtask : t_disable
  // ==========================================================
  // clock, reset, sequence and watchdog
  always #5 hclk = ~hclk;
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      fails++;
      end_sim();
    end
  end
  initial begin
    {hclk, hresetn, hsel, hwrite, htrans, haddr, hwdata} = '0;
    hsize = 3'h2;
    {fails, n_checks, cyc} = '0;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    t_regs();
    t_frames();
    t_tags();
    t_long();
    t_fifo();
    t_disable();
    end_sim();
  end
endmodule : tb_top
